/* hp_params.svh */
// Purpose: Shared constants of the host port pair.
// Assumes: Included by its bare name; the clock runs at 200 MHz.
// Notes: Offsets are byte addresses of the controller's AXI4-Lite window.
`ifndef HP_PARAMS_SVH
`define HP_PARAMS_SVH
`define HP_CLK_MHZ      200
`define HP_IO_BASE      10'h300
`define HP_IO_STEP      10'h010
`define HP_CFG_RWINV    0
`define HP_CFG_WAITHI   1
`define HP_CFG_WAITPP   2
`define HP_CFG_WORDHI   3
`define HP_CFG_DWORDHI  4
`define HP_CFG_INTFLIP  5
`define HP_CFG_W        6
`define HP_T_STROBE_NS  20
`define HP_STROBE_CYC   ((`HP_T_STROBE_NS * `HP_CLK_MHZ + 999) / 1000)
`define HP_REG_CTRL     8'h00
`define HP_REG_ADDR     8'h04
`define HP_REG_WDATA    8'h08
`define HP_REG_RDATA    8'h0C
`define HP_REG_STATUS   8'h10
`define HP_REG_ISTAT    8'h14
`define HP_REG_IMASK    8'h18
`define HP_CTRL_GO      0
`define HP_CTRL_WR      1
`define HP_CTRL_PSEL    2
`define HP_CTRL_RWINV   3
`define HP_CTRL_HWRST   4
`define HP_CTRL_WAITHI  5
`define HP_CTRL_INTLOW  6
`define HP_CTRL_W       7
`define HP_EV_DONE      0
`define HP_EV_DEVINT    1
`define HP_EV_W         2
`define HP_RESP_OKAY    2'h0
`define HP_RESP_SLVERR  2'h2
`endif

/* hp_pkg.sv */
// Purpose: Types of the host port pair.
// Assumes: Constants come from hp_params.svh.
// Notes: Each end keeps all of its state in one packed struct.
`include "hp_params.svh"
package hp_pkg;
	typedef enum logic [1:0] {HP_W16 = 2'h0, HP_W32 = 2'h1, HP_W8 = 2'h2, HP_WRSV = 2'h3} hp_width_e;
	typedef enum logic {HP_DS_IDLE = 1'h0, HP_DS_BUSY = 1'h1} hp_dev_st_e;
	typedef enum logic [1:0] {HP_HS_IDLE = 2'h0, HP_HS_SETUP = 2'h1, HP_HS_STROBE = 2'h3,
		HP_HS_RECOV = 2'h2} hp_host_st_e;
	typedef struct packed {
		hp_dev_st_e            st;
		logic                  served;
		logic [2:0]            base;
		logic                  int_strap;
		logic                  dw_strap;
		hp_width_e             width;
		logic [`HP_CFG_W-1:0]  cfg;
		logic [7:0]            index;
		logic                  we;
		logic [31:0]           wdata;
		logic [31:0]           rdata;
		logic                  drive;
		logic                  word_pin;
		logic                  dword_pin;
		logic                  irq_pin;
	} hp_dev_s;
	typedef struct packed {
		hp_host_st_e           st;
		logic [3:0]            cnt;
		logic [`HP_CTRL_W-1:0] ctrl;
		logic [9:0]            addr;
		logic [31:0]           wdata;
		logic [31:0]           rdata;
		logic [`HP_EV_W-1:0]   ist;
		logic [`HP_EV_W-1:0]   imask;
		logic                  awv;
		logic [7:0]            awaddr;
		logic                  wv;
		logic [31:0]           wd;
		logic [3:0]            ws;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [31:0]           rd;
		logic [1:0]            rresp;
	} hp_host_s;
endpackage

/* hp_if.sv */
// Purpose: Pins between the processor-side controller and the device port.
// Assumes: Data lines and the wait line have pull resistors on the board.
// Notes: Data resolve to zero when nobody drives; the wait line pulls high.
`timescale 1ns/100ps
`default_nettype none
interface hp_if;
	logic [5:0]  host_addr_hi;
	logic        addr_enable_n;
	logic        host_read_n;
	logic        host_write_n;
	logic        port_sel;
	logic        hw_reset;
	logic [31:0] host_d_o;
	logic        host_d_oe_n;
	logic [31:0] dev_d_o;
	logic        dev_d_oe_n;
	logic [15:0] host_data_lo;
	logic [15:0] host_data_hi;
	logic        wait_o;
	logic        wait_oe_n;
	logic        cmd_wait;
	logic        word_access_ind;
	logic        dword_access_ind;
	logic        irq;
	assign {host_data_hi, host_data_lo} = !dev_d_oe_n ? dev_d_o :
		(!host_d_oe_n ? host_d_o : 32'h00000000);
	assign cmd_wait = wait_oe_n ? 1'b1 : wait_o;
	modport dev (input host_addr_hi, addr_enable_n, host_read_n, host_write_n, port_sel,
		hw_reset, host_data_lo, host_data_hi, output dev_d_o, dev_d_oe_n, wait_o,
		wait_oe_n, word_access_ind, dword_access_ind, irq);
	modport host (output host_addr_hi, addr_enable_n, host_read_n, host_write_n, port_sel,
		hw_reset, host_d_o, host_d_oe_n, input host_data_lo, host_data_hi, cmd_wait,
		word_access_ind, dword_access_ind, irq);
endinterface
`default_nettype wire

/* hp_wait_drv.sv */
// Purpose: Pin cell for the command wait line.
// Assumes: The line has a pull-up outside.
// Notes: An open-drain cell can only pull low, so an active-high
//        open-drain wait is shown by releasing the line.
`timescale 1ns/100ps
`default_nettype none
module hp_wait_drv (
	input  wire logic active,
	input  wire logic pol_high,
	input  wire logic push_pull,
	output logic      pin_o,
	output logic      pin_oe_n
);
	logic level;
	assign level = active ~^ pol_high;
	assign pin_o = push_pull ? level : 1'b0;
	assign pin_oe_n = push_pull ? 1'b0 : level;
endmodule
`default_nettype wire

/* hp_dev_end.sv */
// Purpose: Device end of the parallel host port: decode, index port,
//          data port, wait, width indications and interrupt pin.
// Assumes: Pins are synchronous to aclk; straps sit on their pins in reset.
// Notes: Data port accesses are passed to the user side one at a time.
`timescale 1ns/100ps
`default_nettype none
`include "hp_params.svh"
module hp_dev_end (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	hp_if.dev                      intf,
	input  wire logic [2:0]        strap_base,
	input  wire logic              strap_int_pol,
	input  wire logic              cfg_mem_out_strap,
	input  wire logic              strap_wake,
	input  wire logic              strap_dword_ind,
	input  wire logic              cfg_load,
	input  wire logic [`HP_CFG_W-1:0] cfg_bits,
	output logic                   usr_req,
	output logic                   usr_we,
	output logic [7:0]             usr_index,
	output logic [31:0]            usr_wdata,
	output logic [1:0]             usr_width,
	input  wire logic              usr_ack,
	input  wire logic [31:0]       usr_rdata,
	input  wire logic              usr_irq,
	output logic                   dword_mode
);
	hp_pkg::hp_dev_s q;
	hp_pkg::hp_dev_s d;
	logic rst;
	logic rd_act;
	logic wr_act;
	logic act;
	logic sel;
	logic wait_act;
	logic [31:0] bus;

	function automatic logic hp_match(input logic [5:0] a, input logic aen_n,
		input logic [2:0] b, input logic dw);
		logic [9:0] base;
		base = `HP_IO_BASE + 10'(`HP_IO_STEP * b);
		if (dw)
		begin
			hp_match = !aen_n && a[5:3] == base[9:7];
		end
		else
		begin
			hp_match = !aen_n && {a, 4'h0} == base;
		end
	endfunction

	function automatic logic [31:0] hp_lanes(input logic [31:0] v, input hp_pkg::hp_width_e w);
		unique case (w)
			hp_pkg::HP_W8:  hp_lanes = {24'h000000, v[7:0]};
			hp_pkg::HP_W32: hp_lanes = v;
			default:        hp_lanes = {16'h0000, v[15:0]};
		endcase
	endfunction

	// The external reset pin acts beside the system reset.
	assign rst = !aresetn || intf.hw_reset;
	assign bus = {intf.host_data_hi, intf.host_data_lo};
	assign dword_mode = q.width == hp_pkg::HP_W32;
	assign rd_act = (intf.host_read_n ^ q.cfg[`HP_CFG_RWINV]) == 1'b0;
	assign wr_act = (intf.host_write_n ^ q.cfg[`HP_CFG_RWINV]) == 1'b0;
	assign act = rd_act || wr_act;
	assign sel = hp_match(intf.host_addr_hi, intf.addr_enable_n, q.base, dword_mode);
	// A strobe that finds a data access still open is held off until it closes.
	assign wait_act = !rst && sel && act && q.st == hp_pkg::HP_DS_BUSY;

	assign usr_req = q.st == hp_pkg::HP_DS_BUSY;
	assign usr_we = q.we;
	assign usr_index = q.index;
	assign usr_wdata = q.wdata;
	assign usr_width = q.width;

	assign intf.dev_d_o = q.rdata;
	assign intf.dev_d_oe_n = !q.drive;
	assign intf.word_access_ind = q.word_pin;
	assign intf.dword_access_ind = q.dword_pin;
	assign intf.irq = q.irq_pin;

	hp_wait_drv u_wait (
		.active    (wait_act),
		.pol_high  (q.cfg[`HP_CFG_WAITHI]),
		.push_pull (q.cfg[`HP_CFG_WAITPP]),
		.pin_o     (intf.wait_o),
		.pin_oe_n  (intf.wait_oe_n)
	);

	always_comb
	begin
		d = q;
		if (!act)
		begin
			d.served = 1'b0;
		end
		unique case (q.st)
			hp_pkg::HP_DS_IDLE:
			begin
				if (sel && act && !q.served)
				begin
					d.served = 1'b1;
					if (intf.port_sel)
					begin
						d.st = hp_pkg::HP_DS_BUSY;
						d.we = wr_act;
						d.wdata = hp_lanes(bus, q.width);
					end
					else if (wr_act)
					begin
						d.index = bus[7:0];
					end
					else
					begin
						d.rdata = {24'h000000, q.index};
					end
				end
			end
			hp_pkg::HP_DS_BUSY:
			begin
				if (usr_ack)
				begin
					d.st = hp_pkg::HP_DS_IDLE;
					if (!q.we)
					begin
						d.rdata = hp_lanes(usr_rdata, q.width);
					end
				end
			end
		endcase
		d.drive = rd_act && sel && q.served && q.st == hp_pkg::HP_DS_IDLE;
		if (cfg_load)
		begin
			d.cfg = cfg_bits;
		end
		if (rst)
		begin
			d = '0;
			d.base = strap_base;
			d.int_strap = strap_int_pol;
			d.dw_strap = strap_dword_ind;
			d.width = hp_pkg::hp_width_e'({strap_wake, cfg_mem_out_strap});
		end
		// Indications follow the decoded data port address and the latched width.
		d.word_pin = (!rst && sel && intf.port_sel && d.width != hp_pkg::HP_W8)
			^ !d.cfg[`HP_CFG_WORDHI];
		d.dword_pin = (d.width == hp_pkg::HP_W32) &&
			((!rst && sel && intf.port_sel) ^ !d.cfg[`HP_CFG_DWORDHI]);
		// Outside dword mode the clock-pin strap sets the interrupt polarity.
		d.irq_pin = (!rst && usr_irq) ^ d.cfg[`HP_CFG_INTFLIP] ^
			(d.width == hp_pkg::HP_W32 ? d.dw_strap : d.int_strap);
	end

	always_ff @(posedge aclk)
	begin
		q <= d;
	end
endmodule
`default_nettype wire

/* hp_host_end.sv */
// Purpose: Processor-side controller that runs I/O cycles on the port.
// Assumes: Software orders cycles through an AXI4-Lite register window.
// Notes: One cycle at a time; a go while busy is ignored.
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "hp_params.svh"
module hp_host_end (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	hp_if.host               intf,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             irq
);
	hp_pkg::hp_host_s q;
	hp_pkg::hp_host_s d;
	logic waiting;
	logic [`HP_EV_W-1:0] ev;
	logic [7:0] wa;
	logic [7:0] ra;
	logic [31:0] mrg;

	function automatic logic [31:0] hp_merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		for (int i = 0; i < 4; i++)
		begin
			o[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
		end
		hp_merge = o;
	endfunction

	assign waiting = intf.cmd_wait == q.ctrl[`HP_CTRL_WAITHI];
	assign wa = {q.awaddr[7:2], 2'h0};
	assign ra = {s_axi_araddr[7:2], 2'h0};

	assign intf.host_addr_hi = q.addr[9:4];
	assign intf.addr_enable_n = q.st == hp_pkg::HP_HS_IDLE;
	assign intf.port_sel = q.ctrl[`HP_CTRL_PSEL];
	assign intf.host_read_n = !(q.st == hp_pkg::HP_HS_STROBE && !q.ctrl[`HP_CTRL_WR])
		^ q.ctrl[`HP_CTRL_RWINV];
	assign intf.host_write_n = !(q.st == hp_pkg::HP_HS_STROBE && q.ctrl[`HP_CTRL_WR])
		^ q.ctrl[`HP_CTRL_RWINV];
	assign intf.host_d_o = q.wdata;
	assign intf.host_d_oe_n = !(q.ctrl[`HP_CTRL_WR] && q.st != hp_pkg::HP_HS_IDLE);
	assign intf.hw_reset = q.ctrl[`HP_CTRL_HWRST];

	assign s_axi_awready = !q.awv && !q.bvalid;
	assign s_axi_wready = !q.wv && !q.bvalid;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = !q.rvalid;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rd;
	assign s_axi_rresp = q.rresp;
	assign irq = |(q.ist & q.imask);

	always_comb
	begin
		d = q;
		ev = '0;
		mrg = 32'h00000000;
		ev[`HP_EV_DEVINT] = intf.irq ^ q.ctrl[`HP_CTRL_INTLOW];
		unique case (q.st)
			hp_pkg::HP_HS_IDLE:
			begin
				d.cnt = 4'h0;
			end
			hp_pkg::HP_HS_SETUP:
			begin
				d.st = hp_pkg::HP_HS_STROBE;
			end
			hp_pkg::HP_HS_STROBE:
			begin
				// The strobe lasts its least width after the wait line lets go.
				if (waiting)
				begin
					d.cnt = 4'h0;
				end
				else if (q.cnt == 4'(`HP_STROBE_CYC - 1))
				begin
					d.st = hp_pkg::HP_HS_RECOV;
					if (!q.ctrl[`HP_CTRL_WR])
					begin
						d.rdata = {intf.host_data_hi, intf.host_data_lo};
					end
				end
				else
				begin
					d.cnt = q.cnt + 4'h1;
				end
			end
			hp_pkg::HP_HS_RECOV:
			begin
				d.st = hp_pkg::HP_HS_IDLE;
				ev[`HP_EV_DONE] = 1'b1;
			end
		endcase
		if (s_axi_awvalid && s_axi_awready)
		begin
			d.awv = 1'b1;
			d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			d.wv = 1'b1;
			d.wd = s_axi_wdata;
			d.ws = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready)
		begin
			d.bvalid = 1'b0;
		end
		if (q.awv && q.wv)
		begin
			d.awv = 1'b0;
			d.wv = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = `HP_RESP_OKAY;
			unique case (wa)
				`HP_REG_CTRL:
				begin
					mrg = hp_merge({25'h0, q.ctrl}, q.wd, q.ws);
					d.ctrl = mrg[`HP_CTRL_W-1:0];
					d.ctrl[`HP_CTRL_GO] = 1'b0;
					if (q.ws[0] && q.wd[`HP_CTRL_GO] && q.st == hp_pkg::HP_HS_IDLE)
					begin
						d.st = hp_pkg::HP_HS_SETUP;
					end
				end
				`HP_REG_ADDR:
				begin
					mrg = hp_merge({22'h0, q.addr}, q.wd, q.ws);
					d.addr = mrg[9:0];
				end
				`HP_REG_WDATA:  d.wdata = hp_merge(q.wdata, q.wd, q.ws);
				`HP_REG_ISTAT:  d.ist = q.ist & ~(q.ws[0] ? q.wd[`HP_EV_W-1:0] : '0);
				`HP_REG_IMASK:  d.imask = q.ws[0] ? q.wd[`HP_EV_W-1:0] : q.imask;
				`HP_REG_RDATA, `HP_REG_STATUS: d.bresp = `HP_RESP_OKAY;
				default:        d.bresp = `HP_RESP_SLVERR;
			endcase
		end
		// A new event wins over a clear in the same cycle.
		d.ist = d.ist | ev;
		if (q.rvalid && s_axi_rready)
		begin
			d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready)
		begin
			d.rvalid = 1'b1;
			d.rresp = `HP_RESP_OKAY;
			unique case (ra)
				`HP_REG_CTRL:   d.rd = {25'h0, q.ctrl};
				`HP_REG_ADDR:   d.rd = {22'h0, q.addr};
				`HP_REG_WDATA:  d.rd = q.wdata;
				`HP_REG_RDATA:  d.rd = q.rdata;
				`HP_REG_STATUS: d.rd = {31'h0, q.st != hp_pkg::HP_HS_IDLE};
				`HP_REG_ISTAT:  d.rd = {30'h0, q.ist};
				`HP_REG_IMASK:  d.rd = {30'h0, q.imask};
				default:
				begin
					d.rd = 32'h00000000;
					d.rresp = `HP_RESP_SLVERR;
				end
			endcase
		end
		if (!aresetn)
		begin
			d = '0;
		end
	end

	always_ff @(posedge aclk)
	begin
		q <= d;
	end
endmodule
`default_nettype wire

/* hp_sva.sv */
// Purpose: Pin checks between the two ends of the host port.
// Assumes: Strobe, wait and indication polarity stay at their defaults.
// Notes: Polarity set by configuration is not followed here.
`timescale 1ns/100ps
`default_nettype none
module hp_sva (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic [5:0] host_addr_hi,
	input wire logic       addr_enable_n,
	input wire logic       host_read_n,
	input wire logic       host_write_n,
	input wire logic       port_sel,
	input wire logic       hw_reset,
	input wire logic       host_d_oe_n,
	input wire logic       dev_d_oe_n,
	input wire logic       wait_oe_n,
	input wire logic       cmd_wait,
	input wire logic       word_access_ind
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic stb;
	logic sel;
	assign stb = !host_read_n || !host_write_n;
	// Only the fixed upper bits, since the base match moves with the straps.
	assign sel = !addr_enable_n && host_addr_hi[5:3] == 3'h6;
	sequence s_rd_held;
		!host_read_n [*4];
	endsequence
	sequence s_waited;
		stb && !cmd_wait;
	endsequence
	a_strobe_addressed: assert property (stb |-> !addr_enable_n)
		else $error("strobe outside an addressed cycle");
	a_addr_steady: assert property (
		stb && $past(stb) |-> $stable(host_addr_hi) && $stable(port_sel))
		else $error("address moved under a strobe");
	a_wait_selected: assert property (!cmd_wait |-> stb && sel)
		else $error("wait without a selected strobe");
	a_wait_holds: assert property (s_waited |=> stb)
		else $error("strobe ended while waited");
	a_read_min: assert property ($fell(host_read_n) |-> s_rd_held)
		else $error("read strobe too short");
	a_word_cause: assert property ($fell(word_access_ind) |-> $past(sel && port_sel))
		else $error("word indication without a data access");
	a_no_fight: assert property (!(!dev_d_oe_n && !host_d_oe_n))
		else $error("both ends drive the data lines");
	a_hwrst_quiet: assert property (
		hw_reset && $past(hw_reset) |-> dev_d_oe_n && wait_oe_n && word_access_ind)
		else $error("device active during hardware reset");
endmodule
`default_nettype wire

/* tb_isa_style_host_port_decode.sv */
// Purpose: Self-checking bench for the host port pair.
// Assumes: The device user side is answered by a small store here.
// Notes: Strobe and wait polarity stay at their defaults.
`timescale 1ns/100ps
`default_nettype none
`include "hp_params.svh"
`define CHK(n, e, g) \
	begin \
		comparisons++; \
		if ((g) !== (e)) \
		begin \
			err_total++; \
			$display("[ERR] %s expected %0h seen %0h", n, e, g); \
		end \
	end
module tb_isa_style_host_port_decode;
	typedef struct packed {
		logic        wk;
		logic        eo;
		logic [7:0]  ix;
		logic [31:0] wd;
	} hp_row_s;
	hp_row_s rows [6] = '{'{1'b0, 1'b0, 8'h00, 32'h12345678}, '{1'b0, 1'b0, 8'hFF, 32'hFFFF0001},
		'{1'b0, 1'b1, 8'h01, 32'hDEADBEEF}, '{1'b0, 1'b1, 8'h80, 32'h0000FFFF},
		'{1'b1, 1'b0, 8'h02, 32'h000000C3}, '{1'b1, 1'b0, 8'h7F, 32'hFFFFFF3C}};
	// Straps of int, dword ind and width, config flip, then the idle irq level.
	logic [4:0]  pol [4] = '{5'h11, 5'h0D, 5'h12, 5'h08};
	logic        aclk;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, usr_rdata = 32'h0, s_axi_rdata, usr_wdata;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp, usr_width, lw;
	logic [2:0]  strap_base = 3'h5;
	logic        strap_int_pol = 1'b0, cfg_mem_out_strap = 1'b0, strap_wake = 1'b0;
	logic        strap_dword_ind = 1'b0, cfg_load = 1'b0, usr_ack = 1'b0, usr_irq = 1'b0;
	logic [`HP_CFG_W-1:0] cfg_bits = 6'h00;
	logic        usr_req, usr_we, dword_mode;
	logic [7:0]  usr_index;
	logic [31:0] mem [256];
	logic        saw_w = 1'b0, saw_d = 1'b0, saw_wt = 1'b0;
	int          err_total = 0, comparisons = 0, cyc = 0, req_cnt = 0, ack_dly = 0, acnt = 0;
	hp_if hp_if_inst ();
	hp_host_end hp_host_end_inst (.*, .intf(hp_if_inst));
	hp_dev_end hp_dev_end_inst (.*, .intf(hp_if_inst));
	hp_sva hp_sva_inst (.aclk, .aresetn, .host_addr_hi(hp_if_inst.host_addr_hi),
		.addr_enable_n(hp_if_inst.addr_enable_n), .host_read_n(hp_if_inst.host_read_n),
		.host_write_n(hp_if_inst.host_write_n), .port_sel(hp_if_inst.port_sel),
		.hw_reset(hp_if_inst.hw_reset), .host_d_oe_n(hp_if_inst.host_d_oe_n),
		.dev_d_oe_n(hp_if_inst.dev_d_oe_n), .wait_oe_n(hp_if_inst.wait_oe_n),
		.cmd_wait(hp_if_inst.cmd_wait), .word_access_ind(hp_if_inst.word_access_ind));
	initial
	begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	// Slow answers keep an access open so that the strobe that opened it must wait.
	always @(posedge aclk)
	begin
		usr_ack <= 1'b0;
		acnt <= 0;
		if (usr_req === 1'b1 && !usr_ack)
		begin
			acnt <= acnt + 1;
			if (acnt >= ack_dly)
			begin
				usr_ack <= 1'b1;
				usr_rdata <= mem[usr_index];
				lw <= usr_width;
				req_cnt <= req_cnt + 1;
				if (usr_we)
					mem[usr_index] <= usr_wdata;
			end
		end
	end
	always @(posedge aclk)
	begin
		cyc++;
		if (hp_if_inst.word_access_ind === 1'b0)
			saw_w = 1'b1;
		if (dword_mode === 1'b1 && hp_if_inst.dword_access_ind === 1'b0)
			saw_d = 1'b1;
		if (hp_if_inst.cmd_wait === 1'b0)
			saw_wt = 1'b1;
		if (cyc == 40000)
		begin
			err_total++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic rst();
		aresetn <= 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
	endtask
	task automatic axw(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
		while (s_axi_bvalid !== 1'b1)
			@(posedge aclk);
		r = s_axi_bresp;
	endtask
	task automatic axr(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk);
		while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk);
		while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	task automatic io(input logic [9:0] a, input logic wr, ps, input logic [31:0] d,
		output logic [31:0] q);
		logic [1:0]  r;
		logic [31:0] s;
		int          n;
		axw(`HP_REG_ADDR, {22'h0, a}, r);
		axw(`HP_REG_WDATA, d, r);
		axw(`HP_REG_CTRL, {29'h0, ps, wr, 1'b1}, r);
		s = 32'h1;
		n = 0;
		while (s[0] !== 1'b0 && n < 300)
		begin
			axr(`HP_REG_STATUS, s, r);
			n++;
		end
		`CHK("cycle done", 1'b0, s[0])
		axr(`HP_REG_RDATA, q, r);
	endtask
	initial
	begin
		logic [31:0] q;
		logic [31:0] m;
		logic [1:0]  r;
		logic [9:0]  a;
		int          c;
		a = `HP_IO_BASE + `HP_IO_STEP * strap_base;
		foreach (rows[i])
		begin
			strap_wake <= rows[i].wk;
			cfg_mem_out_strap <= rows[i].eo;
			rst();
			m = rows[i].eo ? 32'hFFFFFFFF : (rows[i].wk ? 32'h000000FF : 32'h0000FFFF);
			`CHK("dword_mode", rows[i].eo && !rows[i].wk, dword_mode)
			saw_w = 1'b0;
			io(a, 1'b1, 1'b0, {24'h0, rows[i].ix}, q);
			`CHK("index word ind", 1'b0, saw_w)
			saw_d = 1'b0;
			io(a, 1'b1, 1'b1, rows[i].wd, q);
			`CHK("stored", rows[i].wd & m, mem[rows[i].ix] & m)
			`CHK("width", {rows[i].wk, rows[i].eo}, lw)
			`CHK("word ind", !rows[i].wk, saw_w)
			`CHK("dword ind", rows[i].eo, saw_d)
			io(a, 1'b0, 1'b1, 32'h0, q);
			`CHK("read", rows[i].wd & m, q & m)
			io(a, 1'b0, 1'b0, 32'h0, q);
			`CHK("index read", rows[i].ix, q[7:0])
			$display("row %0d done", i);
		end
		cfg_mem_out_strap <= 1'b0;
		strap_wake <= 1'b0;
		rst();
		for (int k = 0; k < 3; k++)
		begin
			c = req_cnt;
			io(k == 0 ? a ^ 10'h010 : (k == 1 ? a | 10'h080 : a ^ 10'h100), 1'b1, 1'b1, 32'h1, q);
			`CHK("unselected", c, req_cnt)
		end
		ack_dly = 100;
		saw_wt = 1'b0;
		io(a, 1'b1, 1'b0, 32'h00000033, q);
		io(a, 1'b1, 1'b1, 32'h0000AAAA, q);
		io(a, 1'b1, 1'b1, 32'h00005555, q);
		`CHK("wait seen", 1'b1, saw_wt)
		repeat (120) @(posedge aclk);
		`CHK("second write", 16'h5555, mem[8'h33][15:0])
		ack_dly = 0;
		$display("decode and wait done");
		`CHK("masked", 1'b0, irq)
		axw(`HP_REG_IMASK, 32'h1, r);
		repeat (2) @(posedge aclk);
		`CHK("unmasked", 1'b1, irq)
		axw(`HP_REG_ISTAT, 32'h1, r);
		repeat (2) @(posedge aclk);
		`CHK("cleared", 1'b0, irq)
		axw(`HP_REG_IMASK, 32'h2, r);
		usr_irq <= 1'b1;
		repeat (4) @(posedge aclk);
		`CHK("device irq", 1'b1, irq)
		usr_irq <= 1'b0;
		io(a, 1'b1, 1'b0, 32'h0000005A, q);
		axw(`HP_REG_CTRL, 32'h10, r);
		repeat (3) @(posedge aclk);
		`CHK("oe in reset", 1'b1, hp_if_inst.dev_d_oe_n)
		axw(`HP_REG_CTRL, 32'h0, r);
		cfg_mem_out_strap <= 1'b1;
		io(a, 1'b0, 1'b0, 32'h0, q);
		`CHK("index cleared", 8'h00, q[7:0])
		`CHK("straps held", 1'b0, dword_mode)
		axr(8'h40, q, r);
		`CHK("unmapped read", `HP_RESP_SLVERR, r)
		axw(8'h40, 32'h1, r);
		`CHK("unmapped write", `HP_RESP_SLVERR, r)
		rst();
		c = req_cnt;
		io(a ^ 10'h070, 1'b1, 1'b1, 32'h1, q);
		`CHK("base ignored", c + 1, req_cnt)
		$display("irq, reset and decode in wide mode done");
		foreach (pol[j])
		begin
			{strap_int_pol, strap_dword_ind, cfg_mem_out_strap} <= pol[j][4:2];
			rst();
			cfg_bits <= {pol[j][1], 5'h00};
			cfg_load <= 1'b1;
			@(posedge aclk);
			cfg_load <= 1'b0;
			repeat (3) @(posedge aclk);
			`CHK("irq idle", pol[j][0], hp_if_inst.irq)
			usr_irq <= 1'b1;
			repeat (3) @(posedge aclk);
			`CHK("irq active", !pol[j][0], hp_if_inst.irq)
			usr_irq <= 1'b0;
		end
		$display("polarity done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
